//--- logic/sac_ctrl.sv
/*
 * Control and status logic of a 10-bit successive-approximation
 * converter: Wishbone register file, mode and start handling, step
 * sequencer and result store. Assumes an external sample-hold, DAC
 * and comparator whose output arrives without timing relation.
 */
// The Wishbone register port was decided locally.
`timescale 1ns/100ps
module sac_ctrl (
  input wire logic clk_i, // Gear clock, 100 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic [7:0] adr_i, // Wishbone byte address
  input wire logic [31:0] dat_i, // Wishbone write data
  output logic [31:0] dat_o, // Wishbone read data
  input wire logic we_i, // Wishbone write enable
  input wire logic [3:0] sel_i, // Wishbone byte selects
  input wire logic cyc_i, // Wishbone cycle
  input wire logic stb_i, // Wishbone strobe
  output logic ack_o, // Wishbone acknowledge
  input wire logic lp_entry_i, // Pulse on low-power mode entry
  input wire logic comp_i, // Comparator, asynchronous
  output logic [sac_pkg::NUM_CH-1:0] chan_sel_o, // One-hot input switch
  output logic analog_in_enable_o, // Analog input enable
  output logic sample_o, // Sample-hold tracking
  output logic [sac_pkg::RES_W-1:0] dac_code_o, // Trial code to DAC
  output logic conversion_done_irq_o // One-cycle completion pulse
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sac_pkg::sac_state_e state_q;
  logic ack_q;
  logic acc, wr_ctrl, wr_stat, rd_low, rd_high;
  logic start_q, ain_q, eoc_q, busy_q, low_pend_q, irq_q;
  logic [1:0] converter_op_mode_q;
  logic [3:0] channel_select_q;
  logic [2:0] time_q, time_eff;
  logic [3:0] slot_q;
  logic [sac_pkg::RES_W-1:0] sar_q, result_q;
  logic comp_s, slot_end, go, stop_now, commit, discard, last_slot;
  logic [10:0] conv_cnt_q;

  // Register index from a byte address
  function automatic logic hit(input logic [7:0] a, input logic [5:0] i);
    return a[7:2] == i;
  endfunction

  // One successive-approximation decision on bit k
  function automatic logic [9:0] sar_step(input logic [9:0] s,
                                          input logic [3:0] k,
                                          input logic c);
    logic [9:0] r;
    r = s;
    r[k] = c;
    if (k != 4'h0) begin
      r[k-4'h1] = 1'b1;
    end
    return r;
  endfunction

  // Comparator crosses into the gear clock domain
  sac_sync2 #(.W(1)) u_comp_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(comp_i),
    .q_o(comp_s)
  );

  // Reserved time codes run as the longest legal time
  assign time_eff = (time_q > sac_pkg::TIME_CODE_MAX) ?
                    sac_pkg::TIME_CODE_MAX : time_q;

  // Slot pacing for sampling and bit decisions
  sac_slot_timer #(.CNT_W(6)) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(state_q == sac_pkg::SAC_CONV),
    .code_i(time_eff),
    .slot_end_o(slot_end)
  );

  // Bus decode; ack one cycle after the request, then drops
  assign acc = cyc_i && stb_i && !ack_q;
  assign wr_ctrl = acc && we_i && sel_i[0] && hit(adr_i, sac_pkg::IDX_CTRL);
  assign wr_stat = acc && we_i && sel_i[0] && hit(adr_i, sac_pkg::IDX_STAT);
  assign rd_low = acc && !we_i && hit(adr_i, sac_pkg::IDX_RESL);
  assign rd_high = acc && !we_i && hit(adr_i, sac_pkg::IDX_RESH);
  assign ack_o = ack_q;

  // Forced stop by mode 00 or low-power entry; start needs a live mode
  assign stop_now = lp_entry_i || (wr_ctrl &&
    dat_i[sac_pkg::CTRL_MODE_LSB +: 2] == sac_pkg::MODE_OFF);
  assign go = start_q && state_q == sac_pkg::SAC_IDLE && !stop_now &&
    (converter_op_mode_q == sac_pkg::MODE_SINGLE ||
     converter_op_mode_q == sac_pkg::MODE_REPEAT);
  assign last_slot = slot_end && slot_q == 4'(sac_pkg::SLOTS - 1);
  // Completion while a low byte read awaits its high byte is dropped
  assign commit = state_q == sac_pkg::SAC_STORE && !low_pend_q &&
                  !stop_now;
  assign discard = state_q == sac_pkg::SAC_STORE && low_pend_q &&
                   !stop_now;

  // Acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc;
    end
  end

  // Read data captured with the acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (acc && !we_i) begin
      dat_o <= 32'h0000_0000;
      if (hit(adr_i, sac_pkg::IDX_CTRL)) begin
        dat_o[7:0] <= {start_q, converter_op_mode_q, ain_q,
                       channel_select_q};
      end else if (hit(adr_i, sac_pkg::IDX_STAT)) begin
        dat_o[7:0] <= {eoc_q, busy_q, 3'h0, time_q};
      end else if (hit(adr_i, sac_pkg::IDX_RESL)) begin
        dat_o[7:0] <= result_q[7:0];
      end else if (hit(adr_i, sac_pkg::IDX_RESH)) begin
        dat_o[7:0] <= {6'h00, result_q[9:8]};
      end
    end
  end

  // Start bit lives one cycle, so reads see zero once launched
  always_ff @(posedge clk_i) begin
    if (rst_i || lp_entry_i) begin
      start_q <= sac_pkg::RST_CTRL[sac_pkg::CTRL_START_BIT];
    end else if (wr_ctrl) begin
      start_q <= dat_i[sac_pkg::CTRL_START_BIT];
    end else begin
      start_q <= 1'b0;
    end
  end

  // Mode and input enable; both forgotten on low-power entry
  always_ff @(posedge clk_i) begin
    if (rst_i || lp_entry_i) begin
      converter_op_mode_q <= sac_pkg::RST_CTRL[6:5];
      ain_q <= sac_pkg::RST_CTRL[sac_pkg::CTRL_INPUT_EN_BIT];
    end else if (wr_ctrl) begin
      converter_op_mode_q <= dat_i[sac_pkg::CTRL_MODE_LSB +: 2];
      ain_q <= dat_i[sac_pkg::CTRL_INPUT_EN_BIT];
    end
  end

  // Channel and time code survive low-power entry
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      channel_select_q <= sac_pkg::RST_CTRL[3:0];
      time_q <= sac_pkg::RST_STAT[2:0];
    end else begin
      if (wr_ctrl) begin
        channel_select_q <= dat_i[sac_pkg::CTRL_CHAN_LSB +: 4];
      end
      if (wr_stat) begin
        time_q <= dat_i[sac_pkg::STAT_TIME_LSB +: 3];
      end
    end
  end

  // Sequencer: convert, then one store cycle, repeat loops back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= sac_pkg::SAC_IDLE;
    end else begin
      case (state_q)
        sac_pkg::SAC_IDLE: begin
          if (go) begin
            state_q <= sac_pkg::SAC_CONV;
          end
        end
        sac_pkg::SAC_CONV: begin
          if (stop_now) begin
            state_q <= sac_pkg::SAC_IDLE;
          end else if (last_slot) begin
            state_q <= sac_pkg::SAC_STORE;
          end
        end
        sac_pkg::SAC_STORE: begin
          if (!stop_now &&
              converter_op_mode_q == sac_pkg::MODE_REPEAT) begin
            state_q <= sac_pkg::SAC_CONV;
          end else begin
            state_q <= sac_pkg::SAC_IDLE;
          end
        end
        default: begin
          state_q <= sac_pkg::SAC_IDLE;
        end
      endcase
    end
  end

  // Slot counter: three sampling slots, then one per result bit
  always_ff @(posedge clk_i) begin
    if (rst_i || state_q != sac_pkg::SAC_CONV) begin
      slot_q <= 4'h0;
    end else if (slot_end) begin
      slot_q <= slot_q + 4'h1;
    end
  end

  // Trial code; MSB first, decided at each slot end after sampling
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sar_q <= sac_pkg::RST_RESULT;
    end else if (go || (state_q == sac_pkg::SAC_STORE &&
                        converter_op_mode_q == sac_pkg::MODE_REPEAT)) begin
      sar_q <= 10'h200;
    end else if (state_q == sac_pkg::SAC_CONV && slot_end &&
                 slot_q >= 4'(sac_pkg::SAMPLE_SLOTS)) begin
      sar_q <= sar_step(sar_q, 4'(sac_pkg::SLOTS - 1) - slot_q,
                        comp_s);
    end
  end

  // Busy: set after the start is taken, held through repeat loops
  always_ff @(posedge clk_i) begin
    if (rst_i || stop_now) begin
      busy_q <= 1'b0;
    end else if (go) begin
      busy_q <= 1'b1;
    end else if (state_q == sac_pkg::SAC_STORE &&
                 converter_op_mode_q != sac_pkg::MODE_REPEAT) begin
      busy_q <= 1'b0;
    end
  end

  // End flag: completion beats a same-cycle read clear
  always_ff @(posedge clk_i) begin
    if (rst_i || stop_now) begin
      eoc_q <= 1'b0;
    end else if (commit) begin
      eoc_q <= 1'b1;
    end else if (rd_high || (go &&
                 converter_op_mode_q == sac_pkg::MODE_SINGLE)) begin
      eoc_q <= 1'b0;
    end
  end

  // Pending low-byte read guards the result pair against tearing
  always_ff @(posedge clk_i) begin
    if (rst_i || stop_now || rd_high) begin
      low_pend_q <= 1'b0;
    end else if (rd_low) begin
      low_pend_q <= 1'b1;
    end
  end

  // Result store, wiped by a forced stop or low-power entry
  always_ff @(posedge clk_i) begin
    if (rst_i || stop_now) begin
      result_q <= sac_pkg::RST_RESULT;
    end else if (commit) begin
      result_q <= sar_q;
    end
  end

  // Interrupt pulse only for a stored result
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= commit;
    end
  end

  // Analog side; reserved channel codes open every switch
  always_comb begin
    chan_sel_o = '0;
    if (ain_q && !channel_select_q[3]) begin
      chan_sel_o[channel_select_q[2:0]] = 1'b1;
    end
  end
  assign analog_in_enable_o = ain_q;
  assign sample_o = state_q == sac_pkg::SAC_CONV &&
                    slot_q < 4'(sac_pkg::SAMPLE_SLOTS);
  assign dac_code_o = sar_q;
  assign conversion_done_irq_o = irq_q;

  // Cycles spent converting, read only by the checks below
  always_ff @(posedge clk_i) begin
    if (rst_i || state_q != sac_pkg::SAC_CONV) begin
      conv_cnt_q <= 11'h000;
    end else begin
      conv_cnt_q <= conv_cnt_q + 11'h001;
    end
  end

  a_busy_after_go: assert property (go |=> busy_q)
    else $error("busy not set after start");
  a_start_self_clear: assert property (start_q |=> !start_q)
    else $error("start bit did not clear");
  a_force_stop_wipe: assert property (stop_now |=> !busy_q && !eoc_q &&
    result_q == 10'h000 && state_q == sac_pkg::SAC_IDLE)
    else $error("forced stop left state behind");
  a_lowpower_ctrl: assert property (lp_entry_i |=> !start_q &&
    !ain_q && converter_op_mode_q == sac_pkg::MODE_OFF)
    else $error("low-power entry kept control bits");
  a_lowpower_flags: assert property (lp_entry_i |=> !eoc_q && !busy_q &&
    chan_sel_o == '0)
    else $error("low-power entry kept flags");
  a_high_read_clear: assert property (rd_high && !commit |=> !eoc_q)
    else $error("upper result read kept end flag");
  a_done_store: assert property (commit |=> eoc_q &&
    conversion_done_irq_o && result_q == $past(sar_q))
    else $error("completion not stored");
  a_tear_discard: assert property (discard |=> $stable(result_q) &&
    !conversion_done_irq_o)
    else $error("torn result was overwritten");
  a_conv_span: assert property (state_q == sac_pkg::SAC_STORE |->
    conv_cnt_q == 11'(sac_pkg::BASE_PERIODS << time_eff))
    else $error("conversion span wrong");
  a_start_latency: assert property (go |-> ##1
    state_q == sac_pkg::SAC_CONV && busy_q)
    else $error("start overhead too long");
  a_repeat_loop: assert property (state_q == sac_pkg::SAC_STORE &&
    !stop_now && converter_op_mode_q == sac_pkg::MODE_REPEAT |=>
    state_q == sac_pkg::SAC_CONV && busy_q)
    else $error("repeat did not restart");
  a_status_zero: assert property (acc && !we_i &&
    hit(adr_i, sac_pkg::IDX_STAT) |=> dat_o[5:3] == 3'h0)
    else $error("status pad bits not zero");

  c_single_done: cover property (commit &&
    converter_op_mode_q == sac_pkg::MODE_SINGLE);
  c_repeat_twice: cover property (commit ##[1:1000] commit);
  c_stop_busy: cover property (busy_q && stop_now);
  c_discard: cover property (discard);
endmodule

//--- logic/sac_pkg.sv
/*
 * Shared constants for the converter control block: register indexes,
 * field positions, reset values, mode codes and timing figures.
 * Assumes a 32-bit classic Wishbone bus with word-aligned registers.
 */
package sac_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [5:0] IDX_CTRL = 6'h34;
  localparam logic [5:0] IDX_STAT = 6'h35;
  localparam logic [5:0] IDX_RESL = 6'h36;
  localparam logic [5:0] IDX_RESH = 6'h37;
  // Field positions
  localparam int CTRL_START_BIT = 7;
  localparam int CTRL_MODE_LSB = 5;
  localparam int CTRL_INPUT_EN_BIT = 4;
  localparam int CTRL_CHAN_LSB = 0;
  localparam int STAT_EOC_BIT = 7;
  localparam int STAT_BUSY_BIT = 6;
  localparam int STAT_TIME_LSB = 0;
  // Values after reset
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_STAT = 8'h00;
  localparam logic [9:0] RST_RESULT = 10'h000;
  // Operating modes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_REPEAT = 2'h3;
  // Timing: gear clock period, conversion base and slot layout
  localparam int CLK_PERIOD_NS = 10;
  localparam int BASE_PERIODS = 39;
  localparam int SLOTS = 13;
  localparam int SLOT_BASE = BASE_PERIODS / SLOTS;
  localparam int SAMPLE_SLOTS = 3;
  localparam logic [2:0] TIME_CODE_MAX = 3'h4;
  localparam int NUM_CH = 8;
  localparam int RES_W = 10;
  typedef enum logic [1:0] {SAC_IDLE, SAC_CONV, SAC_STORE} sac_state_e;
endpackage

//--- logic/sac_slot_timer.sv
/*
 * Slot timer: while running, pulses once every 3 << code gear cycles.
 * Assumes the code is already limited to the legal range.
 */
`timescale 1ns/100ps
module sac_slot_timer #(
  parameter int CNT_W = 6
) (
  input wire logic clk_i, // Gear clock
  input wire logic rst_i, // Synchronous reset
  input wire logic run_i, // Count while high
  input wire logic [2:0] code_i, // Time code, 0 to 4
  output logic slot_end_o // Last cycle of a slot
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] last;

  // Slot length is the base slot scaled by the code
  assign last = CNT_W'((sac_pkg::SLOT_BASE << code_i) - 1);
  assign slot_end_o = run_i && (cnt_q == last);

  // Restart from zero whenever stopped so each conversion is exact
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i || slot_end_o) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end
endmodule

//--- logic/sac_sync2.sv
/*
 * Two-flop synchroniser for levels arriving from another domain.
 * Assumes the input changes slower than the clock.
 */
`timescale 1ns/100ps
module sac_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i, // Gear clock
  input wire logic rst_i, // Synchronous reset
  input wire logic [W-1:0] d_i, // Asynchronous level
  output logic [W-1:0] q_o // Synchronised level
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule

//--- tb/sac_analog_model.sv
/*
 * Stand-in for the analog core: input switch, sample-hold, DAC and
 * comparator. Assumes a one-hot switch and an active-high sample phase.
 */
`timescale 1ns/100ps
module sac_analog_model (
  input wire logic clk_i, // Gear clock
  input wire logic sample_i, // Track while high
  input wire logic en_i, // Analog input enable
  input wire logic [7:0] chan_sel_i, // One-hot switch
  input wire logic [9:0] offset_i, // Bench shift of all inputs
  input wire logic [9:0] dac_i, // Trial code
  output logic comp_o // High when input at or above trial
);
  logic [9:0] held_q;
  logic [9:0] pick;
  // Input mux; a disabled or unselected switch sees ground
  always_comb begin
    pick = 10'h000;
    for (int c = 0; c < 8; c++) begin
      if (en_i && chan_sel_i[c]) begin
        pick = 10'(c * 127 + 42) + offset_i;
      end
    end
  end
  // Hold freezes once tracking stops, so late input moves are ignored
  always_ff @(posedge clk_i) begin
    if (sample_i) begin
      held_q <= pick;
    end
  end
  assign comp_o = (held_q >= dac_i);
endmodule

//--- tb/sar_adc_control_regs_bench.sv
/*
 * Self-checking bench for the converter control block.
 * Assumes the analog stand-in model and the registered Wishbone slave.
 */
`timescale 1ns/100ps
module sar_adc_control_regs_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0000_0000;
  logic we_i = 1'b0;
  logic [3:0] sel_i = 4'h1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic lp_entry_i = 1'b0;
  logic [9:0] offset = 10'h000;
  logic [31:0] dat_o, rd;
  logic ack_o, comp, ain_en, sample, irq;
  logic [7:0] chan_sel;
  logic [9:0] dac;
  int mismatches = 0;
  int n_compared = 0;
  int cycle_no = 0;
  int t0;

  sac_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
    .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .lp_entry_i(lp_entry_i), .comp_i(comp), .chan_sel_o(chan_sel),
    .analog_in_enable_o(ain_en), .sample_o(sample), .dac_code_o(dac),
    .conversion_done_irq_o(irq));
  sac_analog_model u_core (.clk_i(clk_i), .sample_i(sample),
    .en_i(ain_en), .chan_sel_i(chan_sel), .offset_i(offset),
    .dac_i(dac), .comp_o(comp));

  // Clock and a cycle count for latency checks
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) cycle_no <= cycle_no + 1;

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; request held until ack is sampled high
  task automatic wb(input logic [5:0] idx, input logic wr,
                    input logic [7:0] d);
    int n;
    @(posedge clk_i);
    adr_i <= {idx, 2'b00};
    we_i <= wr;
    dat_i <= {24'h00_0000, d};
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (ack_o !== 1'b1) begin
      mismatches++;
      tally_and_finish();
    end
  endtask

  task automatic rdchk(input logic [5:0] idx, input logic [7:0] exp);
    wb(idx, 1'b0, 8'h00);
    chk(rd, {24'h00_0000, exp});
  endtask

  // Bounded wait for the completion pulse
  task automatic wait_irq();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (irq !== 1'b1 && n < 2000);
    if (irq !== 1'b1) begin
      mismatches++;
      tally_and_finish();
    end
  endtask

  task automatic t_reset();
    rdchk(sac_pkg::IDX_CTRL, sac_pkg::RST_CTRL);
    rdchk(sac_pkg::IDX_STAT, sac_pkg::RST_STAT);
    rdchk(sac_pkg::IDX_RESL, 8'h00);
    rdchk(sac_pkg::IDX_RESH, 8'h00);
    $display("test reset done");
  endtask

  // Every legal time code, each on its own channel
  task automatic t_single_times();
    int lim;
    int d;
    int span;
    logic [9:0] v;
    for (int c = 0; c < 5; c++) begin
      v = 10'((c + 1) * 127 + 42);
      lim = (c < 2) ? 10 : (c < 4) ? 32 : 128;
      wb(sac_pkg::IDX_STAT, 1'b1, 8'(c));
      wb(sac_pkg::IDX_CTRL, 1'b1, 8'hB0 | 8'(c + 1));
      t0 = cycle_no;
      rdchk(sac_pkg::IDX_STAT, 8'h40 | 8'(c));
      rdchk(sac_pkg::IDX_CTRL, 8'h30 | 8'(c + 1));
      chk(32'(chan_sel), 32'h0000_0001 << (c + 1));
      wait_irq();
      d = cycle_no - t0;
      span = sac_pkg::BASE_PERIODS << c;
      chk(32'(int'(d >= span && d <= span + lim)), 1);
      rdchk(sac_pkg::IDX_STAT, 8'h80 | 8'(c));
      rdchk(sac_pkg::IDX_RESL, v[7:0]);
      rdchk(sac_pkg::IDX_RESH, {6'h00, v[9:8]});
      rdchk(sac_pkg::IDX_STAT, 8'(c));
    end
    $display("test single times done");
  endtask

  // Restart without reading the high byte drops the end flag
  task automatic t_restart_clears();
    wb(sac_pkg::IDX_STAT, 1'b1, 8'h00);
    wb(sac_pkg::IDX_CTRL, 1'b1, 8'hB0);
    wait_irq();
    rdchk(sac_pkg::IDX_STAT, 8'h80);
    wb(sac_pkg::IDX_CTRL, 1'b1, 8'hB0);
    rdchk(sac_pkg::IDX_STAT, 8'h40);
    wait_irq();
    rdchk(sac_pkg::IDX_RESH, 8'h00);
    $display("test restart done");
  endtask

  // Repeat mode, completion between low and high reads, then stop
  task automatic t_repeat_guard();
    logic seen;
    wb(sac_pkg::IDX_CTRL, 1'b1, 8'hF2);
    wait_irq();
    rdchk(sac_pkg::IDX_RESL, 8'h28);
    offset <= 10'h100;
    seen = 1'b0;
    repeat (150) begin
      @(posedge clk_i);
      if (irq === 1'b1) seen = 1'b1;
    end
    chk(32'(seen), 32'h0000_0000);
    rdchk(sac_pkg::IDX_RESH, 8'h01);
    rdchk(sac_pkg::IDX_STAT, 8'h40);
    wait_irq();
    rdchk(sac_pkg::IDX_RESL, 8'h28);
    rdchk(sac_pkg::IDX_RESH, 8'h02);
    wait_irq();
    wb(sac_pkg::IDX_CTRL, 1'b1, 8'h12);
    repeat (60) @(posedge clk_i);
    rdchk(sac_pkg::IDX_STAT, 8'h00);
    rdchk(sac_pkg::IDX_RESL, 8'h00);
    rdchk(sac_pkg::IDX_RESH, 8'h00);
    offset <= 10'h000;
    $display("test repeat done");
  endtask

  // Low-power entry in mid-conversion
  task automatic t_low_power();
    wb(sac_pkg::IDX_STAT, 1'b1, 8'h01);
    wb(sac_pkg::IDX_CTRL, 1'b1, 8'hF6);
    repeat (20) @(posedge clk_i);
    lp_entry_i <= 1'b1;
    @(posedge clk_i);
    lp_entry_i <= 1'b0;
    rdchk(sac_pkg::IDX_CTRL, 8'h06);
    rdchk(sac_pkg::IDX_STAT, 8'h01);
    chk(32'(ain_en), 32'h0000_0000);
    chk(32'(chan_sel), 32'h0000_0000);
    $display("test low power done");
  endtask

  // Reserved mode and channel codes, disabled inputs, unmapped place
  task automatic t_misc();
    wb(sac_pkg::IDX_CTRL, 1'b1, 8'hD1);
    rdchk(sac_pkg::IDX_STAT, 8'h01);
    rdchk(sac_pkg::IDX_CTRL, 8'h51);
    wb(sac_pkg::IDX_CTRL, 1'b1, 8'h01);
    chk(32'(chan_sel), 32'h0000_0000);
    wb(sac_pkg::IDX_CTRL, 1'b1, 8'h19);
    chk(32'(chan_sel), 32'h0000_0000);
    chk(32'(ain_en), 32'h0000_0001);
    // A write without its low byte lane must leave the time code alone
    sel_i <= 4'h0;
    wb(sac_pkg::IDX_STAT, 1'b1, 8'h04);
    sel_i <= 4'h1;
    rdchk(sac_pkg::IDX_STAT, 8'h01);
    wb(6'h10, 1'b1, 8'hFF);
    rdchk(6'h10, 8'h00);
    $display("test misc done");
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_single_times();
    t_restart_clears();
    t_repeat_guard();
    t_low_power();
    t_misc();
    tally_and_finish();
  end
endmodule
